// ===== rtl/sjp_pkg.sv
// shared constants and types for the scan test and emulation port
package sjp_pkg;

    // tap controller states, one-hot
    typedef enum logic [15:0] {
        ST_TLR = 16'h0001,
        ST_RTI = 16'h0002,
        ST_SEL_DR = 16'h0004,
        ST_CAP_DR = 16'h0008,
        ST_SHF_DR = 16'h0010,
        ST_EX1_DR = 16'h0020,
        ST_PAU_DR = 16'h0040,
        ST_EX2_DR = 16'h0080,
        ST_UPD_DR = 16'h0100,
        ST_SEL_IR = 16'h0200,
        ST_CAP_IR = 16'h0400,
        ST_SHF_IR = 16'h0800,
        ST_EX1_IR = 16'h1000,
        ST_PAU_IR = 16'h2000,
        ST_EX2_IR = 16'h4000,
        ST_UPD_IR = 16'h8000
    } sjp_state_e;

    // instruction register
    localparam int IR_W = 4;
    localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;
    localparam logic [IR_W-1:0] INS_IDCODE = 4'h1;
    localparam logic [IR_W-1:0] INS_EMU_DIR = 4'h2;
    localparam logic [IR_W-1:0] INS_BYPASS = 4'hf;
    localparam logic [IR_W-1:0] IR_RESET = INS_IDCODE;

    // data register lengths
    localparam int DR_W = 32;
    localparam int EMU_DIR_W = 2;
    localparam logic [EMU_DIR_W-1:0] EMU_DIR_RESET = 2'h0;

    // synchroniser reset value
    localparam logic SYNC_RESET = 1'h0;

endpackage

// ===== rtl/sjp_sync.sv
// three-stage synchroniser, output changes once stages two and three agree
`timescale 1ns/1ps
module sjp_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // data
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] s1_r;
    logic [WIDTH-1:0] s2_r;
    logic [WIDTH-1:0] s3_r;
    logic [WIDTH-1:0] q_r;

    if (WIDTH < 1)
    begin : g_bad_width
        $error("sjp_sync width must be at least one");
    end

    for (genvar i = 0; i < WIDTH; i++)
    begin : g_bit
        always_ff @(posedge clk_i)
        begin
            if (rst_i)
            begin
                s1_r[i] <= sjp_pkg::SYNC_RESET;
                s2_r[i] <= sjp_pkg::SYNC_RESET;
                s3_r[i] <= sjp_pkg::SYNC_RESET;
                q_r[i] <= sjp_pkg::SYNC_RESET;
            end
            else
            begin
                s1_r[i] <= d_i[i];
                s2_r[i] <= s1_r[i];
                s3_r[i] <= s2_r[i];
                if (s2_r[i] == s3_r[i])
                begin
                    q_r[i] <= s3_r[i];
                end
            end
        end
    end

    assign q_o = q_r;

endmodule

// ===== rtl/sjp_tap_fsm.sv
// sixteen-state tap controller stepped by mode select on rising test clock
`timescale 1ns/1ps
module sjp_tap_fsm (
    // test clock and hold
    input wire logic tck_i,
    input wire logic hold_i,
    // mode select
    input wire logic tms_i,
    // state
    output sjp_pkg::sjp_state_e state_o
);

    sjp_pkg::sjp_state_e state_r;
    sjp_pkg::sjp_state_e state_nxt;

    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            sjp_pkg::ST_TLR: state_nxt = tms_i ? sjp_pkg::ST_TLR : sjp_pkg::ST_RTI;
            sjp_pkg::ST_RTI: state_nxt = tms_i ? sjp_pkg::ST_SEL_DR : sjp_pkg::ST_RTI;
            sjp_pkg::ST_SEL_DR: state_nxt = tms_i ? sjp_pkg::ST_SEL_IR : sjp_pkg::ST_CAP_DR;
            sjp_pkg::ST_CAP_DR: state_nxt = tms_i ? sjp_pkg::ST_EX1_DR : sjp_pkg::ST_SHF_DR;
            sjp_pkg::ST_SHF_DR: state_nxt = tms_i ? sjp_pkg::ST_EX1_DR : sjp_pkg::ST_SHF_DR;
            sjp_pkg::ST_EX1_DR: state_nxt = tms_i ? sjp_pkg::ST_UPD_DR : sjp_pkg::ST_PAU_DR;
            sjp_pkg::ST_PAU_DR: state_nxt = tms_i ? sjp_pkg::ST_EX2_DR : sjp_pkg::ST_PAU_DR;
            sjp_pkg::ST_EX2_DR: state_nxt = tms_i ? sjp_pkg::ST_UPD_DR : sjp_pkg::ST_SHF_DR;
            sjp_pkg::ST_UPD_DR: state_nxt = tms_i ? sjp_pkg::ST_SEL_DR : sjp_pkg::ST_RTI;
            sjp_pkg::ST_SEL_IR: state_nxt = tms_i ? sjp_pkg::ST_TLR : sjp_pkg::ST_CAP_IR;
            sjp_pkg::ST_CAP_IR: state_nxt = tms_i ? sjp_pkg::ST_EX1_IR : sjp_pkg::ST_SHF_IR;
            sjp_pkg::ST_SHF_IR: state_nxt = tms_i ? sjp_pkg::ST_EX1_IR : sjp_pkg::ST_SHF_IR;
            sjp_pkg::ST_EX1_IR: state_nxt = tms_i ? sjp_pkg::ST_UPD_IR : sjp_pkg::ST_PAU_IR;
            sjp_pkg::ST_PAU_IR: state_nxt = tms_i ? sjp_pkg::ST_EX2_IR : sjp_pkg::ST_PAU_IR;
            sjp_pkg::ST_EX2_IR: state_nxt = tms_i ? sjp_pkg::ST_UPD_IR : sjp_pkg::ST_SHF_IR;
            sjp_pkg::ST_UPD_IR: state_nxt = tms_i ? sjp_pkg::ST_SEL_DR : sjp_pkg::ST_RTI;
            default: state_nxt = sjp_pkg::ST_TLR;
        endcase
    end

    // held in test-logic-reset while the scan system is not in control
    always_ff @(posedge tck_i)
    begin
        if (hold_i)
        begin
            state_r <= sjp_pkg::ST_TLR;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    assign state_o = state_r;

endmodule

// ===== rtl/sjp_port.sv
// scan test access port with emulator lines and global output disable
`timescale 1ns/1ps
//
// Behaviour
// - test reset high gives scan system control
// - test reset low: functional, tap inputs ignored
// - mode select and data in taken rising
// - selected register shifted out on falling edge
// - data output driven only during data scan
// - disable needs reset low, line a high, b low
// - test reset high: emulator lines bidirectional interrupts
// - test reset low: line b is disable input
// - disable condition floats every device output driver
module sjp_port #(
    parameter logic [31:0] ID_VALUE = 32'h00000001 // arbitrary identity value
) (
    // system clock and reset
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    // test access port
    input wire logic tck_i,
    input wire logic trst_i,
    input wire logic tms_i,
    input wire logic tdi_i,
    output logic tdo_o,
    output logic tdo_oe_o,
    // emulator line a
    input wire logic emulator_line_a_i,
    output logic emulator_line_a_o,
    output logic emulator_line_a_oe_o,
    // emulator line b / output disable
    input wire logic emulator_line_b_output_disable_i,
    output logic emulator_line_b_output_disable_o,
    output logic emulator_line_b_output_disable_oe_o,
    // core side
    input wire logic emu_irq_a_req_i,
    input wire logic emu_irq_b_req_i,
    output logic emu_irq_a_o,
    output logic emu_irq_b_o,
    output logic scan_control_o,
    output logic outputs_off_o
);

    localparam int IRW = sjp_pkg::IR_W;
    localparam int DRW = sjp_pkg::DR_W;
    localparam int EDW = sjp_pkg::EMU_DIR_W;

    if (ID_VALUE[0] != 1'b1)
    begin : g_bad_id
        $error("identity value must have bit zero set");
    end

    if (EDW != 2 || DRW < EDW)
    begin : g_bad_dir
        $error("direction register must hold one bit per emulator line");
    end

    // test clock domain: test reset seen on the test clock
    logic trst_tck;
    logic tap_hold;

    sjp_sync #(
        .WIDTH(1)
    ) u_sync_tck (
        .clk_i(tck_i),
        .rst_i(1'b0),
        .d_i(trst_i),
        .q_o(trst_tck)
    );

    assign tap_hold = ~trst_tck;

    sjp_pkg::sjp_state_e state;

    sjp_tap_fsm u_fsm (
        .tck_i(tck_i),
        .hold_i(tap_hold),
        .tms_i(tms_i),
        .state_o(state)
    );

    // state decodes
    wire in_tlr = (state == sjp_pkg::ST_TLR);
    wire cap_ir = (state == sjp_pkg::ST_CAP_IR);
    wire shf_ir = (state == sjp_pkg::ST_SHF_IR);
    wire upd_ir = (state == sjp_pkg::ST_UPD_IR);
    wire cap_dr = (state == sjp_pkg::ST_CAP_DR);
    wire shf_dr = (state == sjp_pkg::ST_SHF_DR);
    wire upd_dr = (state == sjp_pkg::ST_UPD_DR);

    // instruction register
    logic [IRW-1:0] ir_sh_r;
    logic [IRW-1:0] ir_r;

    always_ff @(posedge tck_i)
    begin
        if (cap_ir)
        begin
            ir_sh_r <= sjp_pkg::IR_CAPTURE;
        end
        else if (shf_ir)
        begin
            ir_sh_r <= {tdi_i, ir_sh_r[IRW-1:1]};
        end
    end

    always_ff @(posedge tck_i)
    begin
        if (in_tlr)
        begin
            ir_r <= sjp_pkg::IR_RESET;
        end
        else if (upd_ir)
        begin
            ir_r <= ir_sh_r;
        end
    end

    // data register selection
    wire sel_id = (ir_r == sjp_pkg::INS_IDCODE);
    wire sel_emu = (ir_r == sjp_pkg::INS_EMU_DIR);
    wire sel_byp = ~sel_id & ~sel_emu;

    logic [DRW-1:0] dr_sh_r;
    logic [EDW-1:0] emu_dir_r;

    wire [DRW-1:0] dr_cap_val = sel_id ? ID_VALUE :
                               sel_emu ? {{(DRW-EDW){1'b0}}, emu_dir_r} :
                               {DRW{1'b0}};
    wire [DRW-1:0] dr_shf_val = sel_id ? {tdi_i, dr_sh_r[DRW-1:1]} :
                               sel_emu ? {{(DRW-EDW){1'b0}}, tdi_i, dr_sh_r[EDW-1:1]} :
                               {{(DRW-1){1'b0}}, tdi_i};

    always_ff @(posedge tck_i)
    begin
        if (cap_dr)
        begin
            dr_sh_r <= dr_cap_val;
        end
        else if (shf_dr)
        begin
            dr_sh_r <= dr_shf_val;
        end
    end

    // emulator line directions, set through the scan chain
    always_ff @(posedge tck_i)
    begin
        if (in_tlr)
        begin
            emu_dir_r <= sjp_pkg::EMU_DIR_RESET;
        end
        else if (upd_dr && sel_emu)
        begin
            emu_dir_r <= dr_sh_r[EDW-1:0];
        end
    end

    // test data output, changed only on falling test clock
    wire tdo_val = shf_ir ? ir_sh_r[0] : dr_sh_r[0];
    logic tdo_r;
    logic tdo_oe_r;

    always_ff @(negedge tck_i)
    begin
        if (tap_hold)
        begin
            tdo_r <= 1'b0;
            tdo_oe_r <= 1'b0;
        end
        else
        begin
            tdo_r <= tdo_val;
            tdo_oe_r <= shf_dr;
        end
    end

    assign tdo_o = tdo_r;
    assign tdo_oe_o = tdo_oe_r;

    // system clock domain: pins and scan-set directions
    logic [2+EDW:0] sys_sync;

    sjp_sync #(
        .WIDTH(3 + EDW)
    ) u_sync_sys (
        .clk_i(clk_sys_i),
        .rst_i(sys_rst_i),
        .d_i({emu_dir_r, emulator_line_b_output_disable_i, emulator_line_a_i, trst_i}),
        .q_o(sys_sync)
    );

    wire trst_s = sys_sync[0];
    wire line_a_s = sys_sync[1];
    wire line_b_s = sys_sync[2];
    wire [EDW-1:0] dir_sync = sys_sync[2+EDW:3];

    // adopt the direction pair only once it holds for two cycles
    logic [EDW-1:0] dir_seen_r;
    logic [EDW-1:0] dir_r;

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            dir_seen_r <= sjp_pkg::EMU_DIR_RESET;
        end
        else
        begin
            dir_seen_r <= dir_sync;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            dir_r <= sjp_pkg::EMU_DIR_RESET;
        end
        else if (dir_sync == dir_seen_r)
        begin
            dir_r <= dir_sync;
        end
    end

    wire dir_a_s = dir_r[0];
    wire dir_b_s = dir_r[1];

    // global output disable
    wire off_nxt = ~trst_s & line_a_s & ~line_b_s;

    // emulator lines as interrupts in scan mode
    wire a_oe_nxt = trst_s & dir_a_s & ~off_nxt;
    wire b_oe_nxt = trst_s & dir_b_s & ~off_nxt;
    wire irq_a_nxt = trst_s & ~dir_a_s & line_a_s;
    wire irq_b_nxt = trst_s & ~dir_b_s & line_b_s;

    logic scan_r;
    logic off_r;
    logic a_oe_r;
    logic b_oe_r;
    logic a_out_r;
    logic b_out_r;
    logic irq_a_r;
    logic irq_b_r;

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            scan_r <= 1'b0;
            off_r <= 1'b0;
        end
        else
        begin
            scan_r <= trst_s;
            off_r <= off_nxt;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            a_oe_r <= 1'b0;
            b_oe_r <= 1'b0;
        end
        else
        begin
            a_oe_r <= a_oe_nxt;
            b_oe_r <= b_oe_nxt;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            a_out_r <= 1'b0;
            b_out_r <= 1'b0;
        end
        else
        begin
            a_out_r <= emu_irq_a_req_i;
            b_out_r <= emu_irq_b_req_i;
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (sys_rst_i)
        begin
            irq_a_r <= 1'b0;
            irq_b_r <= 1'b0;
        end
        else
        begin
            irq_a_r <= irq_a_nxt;
            irq_b_r <= irq_b_nxt;
        end
    end

    assign scan_control_o = scan_r;
    assign outputs_off_o = off_r;
    assign emulator_line_a_o = a_out_r;
    assign emulator_line_a_oe_o = a_oe_r;
    assign emulator_line_b_output_disable_o = b_out_r;
    assign emulator_line_b_output_disable_oe_o = b_oe_r;
    assign emu_irq_a_o = irq_a_r;
    assign emu_irq_b_o = irq_b_r;

endmodule

// ===== dv/sjp_port_chk.sv
// assertions for the scan test and emulation port
`timescale 1ns/1ps
module sjp_port_chk (
    // clocks and resets
    input wire logic clk_sys_i,
    input wire logic sys_rst_i,
    input wire logic tck_i,
    input wire logic trst_i,
    // pins
    input wire logic tms_i,
    input wire logic tdo_o,
    input wire logic tdo_oe_o,
    input wire logic emulator_line_a_i,
    input wire logic emulator_line_a_oe_o,
    input wire logic emulator_line_b_output_disable_i,
    input wire logic emulator_line_b_output_disable_oe_o,
    // core side
    input wire logic scan_control_o,
    input wire logic outputs_off_o
);
    logic tdo_rise_r;
    wire logic off_req;
    assign off_req = !trst_i && emulator_line_a_i && !emulator_line_b_output_disable_i;
    always_ff @(posedge tck_i)
        tdo_rise_r <= tdo_o;
    AST_SCAN: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        trst_i [*6] |=> scan_control_o) else $error("no scan control");
    AST_FUNC: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        !trst_i [*6] |=> !scan_control_o && !emulator_line_a_oe_o
        && !emulator_line_b_output_disable_oe_o) else $error("scan in functional mode");
    AST_OFF_ON: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        off_req [*6] |=> outputs_off_o) else $error("disable missed");
    AST_OFF_NO: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        !off_req [*6] |=> !outputs_off_o) else $error("disable unwanted");
    AST_FLOAT: assert property (@(posedge clk_sys_i) disable iff (sys_rst_i)
        outputs_off_o [*2] |-> !emulator_line_a_oe_o && !emulator_line_b_output_disable_oe_o)
        else $error("driver on while disabled");
    AST_TDO_FALL: assert property (@(negedge tck_i) disable iff (!trst_i)
        tdo_o == tdo_rise_r) else $error("tdo moved on rise");
    AST_OE_OFF: assert property (@(posedge tck_i) disable iff (!trst_i)
        tdo_oe_o && tms_i |=> !tdo_oe_o) else $error("tdo kept after scan");
    AST_OE_ON: assert property (@(posedge tck_i) disable iff (!trst_i)
        $rose(tdo_oe_o) |-> !$past(tms_i) && !$past(tms_i, 2)) else $error("tdo early");
    COV_OFF: cover property (@(posedge clk_sys_i) $rose(outputs_off_o));
    COV_SHIFT: cover property (@(posedge tck_i) $rose(tdo_oe_o));
    COV_CTL: cover property (@(posedge clk_sys_i) $fell(scan_control_o));
endmodule

// ===== dv/sjp_emu_pod.sv
// emulator pod model driving the test port
`timescale 1ns/1ps
module sjp_emu_pod (
    // pins to the device
    output logic tck_o,
    output logic trst_o,
    output logic tms_o,
    output logic tdi_o,
    output logic line_a_o,
    output logic line_b_o,
    // pins from the device
    input wire logic tdo_i,
    input wire logic tdo_oe_i
);
    initial
    begin
        tck_o = 1'b0;
        tms_o = 1'b1;
        tdi_o = 1'b0;
        pins(1'b0, 1'b0, 1'b1);
        #3;
        forever #7.5 tck_o = ~tck_o;
    end
    // disable is only set up by test sequences
    task automatic pins(input logic t, input logic a, input logic b);
        trst_o = t;
        line_a_o = a;
        line_b_o = b;
    endtask
    task automatic step(input logic ms, input logic di, output logic dq, output logic oe);
        @(negedge tck_o);
        #1;
        tms_o = ms;
        tdi_o = di;
        @(posedge tck_o);
        dq = tdo_i;
        oe = tdo_oe_i;
    endtask
    // idle to idle scan, ir picks the instruction path
    task automatic scan(input logic ir, input logic [31:0] din, input int n,
        output logic [31:0] dq, output logic oi, output logic oo);
        logic d;
        dq = '0;
        step(1'b1, 1'b0, d, oi);
        if (ir)
            step(1'b1, 1'b0, d, oi);
        step(1'b0, 1'b0, d, oi);
        step(1'b0, 1'b0, d, oi);
        for (int i = 0; i < n; i++)
            step(i == n - 1, din[i], dq[i], oi);
        step(1'b1, 1'b0, d, oo);
        step(1'b0, 1'b0, d, d);
    endtask
endmodule

// ===== dv/sjp_port_tb.sv
// testbench for the scan test and emulation port
`timescale 1ns/1ps
module sjp_port_tb;
    localparam logic [31:0] ID = 32'h00000001; // arbitrary identity value
    logic clk_sys_i, sys_rst_i, req_a, req_b;
    wire logic tck, trst, tms, tdi, pod_a, pod_b;
    logic tdo, tdo_oe, a_o, a_oe, b_o, b_oe, irq_a, irq_b, scan, off;
    wire logic a_w = a_oe ? a_o : pod_a;
    wire logic b_w = b_oe ? b_o : pod_b;
    wire logic tdo_w = tdo_oe ? tdo : ~tdo;
    int miscompares = 0;
    int compares = 0;
    sjp_port #(.ID_VALUE(ID)) sjp_port_i (
        .clk_sys_i(clk_sys_i),
        .sys_rst_i(sys_rst_i),
        .tck_i(tck),
        .trst_i(trst),
        .tms_i(tms),
        .tdi_i(tdi),
        .tdo_o(tdo),
        .tdo_oe_o(tdo_oe),
        .emulator_line_a_i(a_w),
        .emulator_line_a_o(a_o),
        .emulator_line_a_oe_o(a_oe),
        .emulator_line_b_output_disable_i(b_w),
        .emulator_line_b_output_disable_o(b_o),
        .emulator_line_b_output_disable_oe_o(b_oe),
        .emu_irq_a_req_i(req_a),
        .emu_irq_b_req_i(req_b),
        .emu_irq_a_o(irq_a),
        .emu_irq_b_o(irq_b),
        .scan_control_o(scan),
        .outputs_off_o(off)
    );
    sjp_emu_pod sjp_emu_pod_i (
        .tck_o(tck),
        .trst_o(trst),
        .tms_o(tms),
        .tdi_o(tdi),
        .line_a_o(pod_a),
        .line_b_o(pod_b),
        .tdo_i(tdo_w),
        .tdo_oe_i(tdo_oe)
    );
    task automatic end_sim;
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", s, e, g);
        end
    endtask
    task automatic t_idcode;
        logic [31:0] q;
        logic oi, oo;
        repeat (5) sjp_emu_pod_i.step(1'b1, 1'b0, oi, oo);
        sjp_emu_pod_i.step(1'b0, 1'b0, oi, oo);
        sjp_emu_pod_i.scan(1'b0, 32'h0, 32, q, oi, oo);
        chk("idcode", ID, q);
        chk("tdo_oe shift", 32'h1, 32'(oi));
        chk("tdo_oe exit", 32'h0, 32'(oo));
        $display("test idcode done");
    endtask
    task automatic t_bypass;
        logic [31:0] q;
        logic oi, oo;
        sjp_emu_pod_i.scan(1'b1, 32'hf, 4, q, oi, oo);
        chk("tdo_oe ir", 32'h0, 32'(oi));
        sjp_emu_pod_i.scan(1'b0, 32'hb, 4, q, oi, oo);
        chk("bypass", 32'h6, q);
        $display("test bypass done");
    endtask
    task automatic t_emu;
        logic [31:0] q;
        logic oi, oo;
        sjp_emu_pod_i.scan(1'b1, 32'h2, 4, q, oi, oo);
        sjp_emu_pod_i.scan(1'b0, 32'h1, 2, q, oi, oo);
        wt(1);
        req_a = 1'b1;
        sjp_emu_pod_i.pins(1'b1, 1'b0, 1'b0);
        wt(8);
        chk("lines", 32'hc, 32'({a_oe, a_w, b_oe, irq_b}));
        req_a = 1'b0;
        sjp_emu_pod_i.pins(1'b1, 1'b0, 1'b1);
        wt(8);
        chk("lines", 32'h9, 32'({a_oe, a_w, b_oe, irq_b}));
        chk("scan control", 32'h1, 32'(scan));
        sjp_emu_pod_i.scan(1'b0, 32'h2, 2, q, oi, oo);
        chk("emu dir readback", 32'h1, q);
        wt(1);
        req_b = 1'b1;
        sjp_emu_pod_i.pins(1'b1, 1'b1, 1'b0);
        wt(16);
        chk("lines swapped", 32'hb, 32'({irq_a, a_oe, b_oe, b_w}));
        req_b = 1'b0;
        $display("test emulator lines done");
    endtask
    task automatic t_off;
        logic [31:0] q;
        logic oi, oo;
        req_a = 1'b1;
        sjp_emu_pod_i.pins(1'b1, 1'b1, 1'b0);
        wt(8);
        chk("off in scan", 32'h0, 32'(off));
        sjp_emu_pod_i.pins(1'b0, 1'b1, 1'b0);
        wt(8);
        chk("off", 32'h1, 32'(off));
        chk("drivers", 32'h0, 32'({scan, a_oe, b_oe}));
        sjp_emu_pod_i.scan(1'b0, 32'h0, 32, q, oi, oo);
        chk("tdo_oe ignored", 32'h0, 32'(oi));
        wt(1);
        sjp_emu_pod_i.pins(1'b0, 1'b0, 1'b0);
        wt(8);
        chk("off released", 32'h0, 32'(off));
        $display("test output disable done");
    endtask
    initial
    begin
        clk_sys_i = 1'b0;
        forever #10 clk_sys_i = ~clk_sys_i;
    end
    initial
    begin
        #50000;
        miscompares++;
        end_sim();
    end
    initial
    begin
        sys_rst_i = 1'b1;
        req_a = 1'b0;
        req_b = 1'b0;
        wt(8);
        sys_rst_i = 1'b0;
        sjp_emu_pod_i.pins(1'b1, 1'b0, 1'b1);
        repeat (4) @(posedge tck);
        t_idcode();
        t_bypass();
        t_emu();
        t_off();
        end_sim();
    end
endmodule
bind sjp_port sjp_port_chk sjp_port_chk_i (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .tck_i(tck_i),
    .trst_i(trst_i),
    .tms_i(tms_i),
    .tdo_o(tdo_o),
    .tdo_oe_o(tdo_oe_o),
    .emulator_line_a_i(emulator_line_a_i),
    .emulator_line_a_oe_o(emulator_line_a_oe_o),
    .emulator_line_b_output_disable_i(emulator_line_b_output_disable_i),
    .emulator_line_b_output_disable_oe_o(emulator_line_b_output_disable_oe_o),
    .scan_control_o(scan_control_o),
    .outputs_off_o(outputs_off_o)
);
